// ==== conv_fec_encoder.sv ====
// Purpose: Feed-forward convolutional encoder with AHB-Lite control and a stream port.
// Assumes: One clock core_clk_i at 100 MHz; rstn_i asynchronous, active low.
// Notes:   Generator codes are octal-valued parameters; taps that are zero vanish in synthesis.
`timescale 1ns/1ps
`default_nettype none
`include "conv_fec_regs.svh"

module conv_fec_encoder
	import conv_fec_pkg::*;
#(
	parameter int                CONSTRAINT_LEN = 7,
	parameter int                NUM_CODES      = 2,
	parameter logic [7*32-1:0]   CODES          = {160'h0, 32'o133, 32'o171},
	parameter bit                USE_ENABLE     = 1'b1
) (
	input  wire logic                 core_clk_i,
	input  wire logic                 rstn_i,
	input  wire logic                 enc_rst_i,
	input  wire logic                 enable_i,
	input  wire logic                 din_i,
	input  wire logic                 vin_i,
	output logic                      vin_ready_o,
	output logic [NUM_CODES-1:0]      code_out_o,
	output logic                      vout_o,
	input  wire logic                 vout_ready_i,
	input  wire logic                 hsel_i,
	input  wire logic [31:0]          haddr_i,
	input  wire logic [1:0]           htrans_i,
	input  wire logic                 hwrite_i,
	input  wire logic [2:0]           hsize_i,
	input  wire logic [31:0]          hwdata_i,
	input  wire logic                 hready_i,
	output logic [31:0]               hrdata_o,
	output logic                      hreadyout_o,
	output logic                      hresp_o
);
	localparam int STAGES = CONSTRAINT_LEN - 1;
	localparam int DW     = NUM_CODES;

	// A mistyped code count is caught at elaboration rather than as odd output.
	if (NUM_CODES < `CFE_CODES_MIN || NUM_CODES > `CFE_CODES_MAX) begin : g_bad_codes
		$error("generator code count out of range");
	end

	// Tap masks: bit CONSTRAINT_LEN-1 of a code weights the newest bit.
	logic [CONSTRAINT_LEN-1:0] tap_mask [NUM_CODES];
	genvar gi;
	for (gi = 0; gi < NUM_CODES; gi++) begin : g_taps
		assign tap_mask[gi] = CODES[gi*32 +: CONSTRAINT_LEN];
	end

	// Pin-side inputs except vout_ready_i and the bus pass two flip-flops before any logic reads them.
	logic [1:0] sync_rst_r;
	logic [1:0] sync_en_r;
	logic [1:0] sync_din_r;
	logic [1:0] sync_vin_r;
	logic [1:0] sync_rst_nxt;
	logic [1:0] sync_en_nxt;
	logic [1:0] sync_din_nxt;
	logic [1:0] sync_vin_nxt;

	always_comb begin
		sync_rst_nxt = {sync_rst_r[0], enc_rst_i};
		sync_en_nxt  = {sync_en_r[0], enable_i};
		sync_din_nxt = {sync_din_r[0], din_i};
		sync_vin_nxt = {sync_vin_r[0], vin_i};
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync_rst_r <= 2'h0;
			sync_en_r  <= 2'h0;
			sync_din_r <= 2'h0;
			sync_vin_r <= 2'h0;
		end else begin
			sync_rst_r <= sync_rst_nxt;
			sync_en_r  <= sync_en_nxt;
			sync_din_r <= sync_din_nxt;
			sync_vin_r <= sync_vin_nxt;
		end
	end

	// Register file state.
	logic [31:0]           ctrl_r;
	logic [31:0]           ctrl_nxt;
	logic [31:0]           in_cnt_r;
	logic [31:0]           in_cnt_nxt;
	logic [31:0]           hrdata_r;
	logic [31:0]           hrdata_nxt;
	ahb_phase_t            phase_r;
	ahb_phase_t            phase_nxt;
	logic [11:0]           wadr_r;
	logic [11:0]           wadr_nxt;
	logic                  sw_push;
	logic                  sw_bit;
	logic                  sw_pop;

	// Encoder state.
	logic [STAGES-1:0]     shreg_r;
	logic [STAGES-1:0]     shreg_nxt;
	logic                  src_valid;
	logic                  src_bit;
	logic                  run_en;
	logic                  clear;
	logic                  take;
	logic [CONSTRAINT_LEN-1:0] window;
	logic [DW-1:0]         code_bits;

	// Buffer between encoder and consumer.
	logic                  buf_in_ready;
	logic                  buf_out_valid;
	logic                  buf_out_ready;
	logic [DW-1:0]         buf_out_data;
	logic                  buf_full;

	assign run_en    = USE_ENABLE ? (sync_en_r[1] & ctrl_r[`CFE_CTRL_EN_BIT]) : 1'b1;
	assign clear     = sync_rst_r[1] | ctrl_r[`CFE_CTRL_CLR_BIT];
	// Software may feed bits instead of the pins; the mode bit chooses the source.
	assign src_valid = ctrl_r[`CFE_CTRL_SRC_BIT] ? sw_push : sync_vin_r[1];
	assign src_bit   = ctrl_r[`CFE_CTRL_SRC_BIT] ? sw_bit : sync_din_r[1];
	// A bit is taken only with valid, enable and buffer room, so stalls lose nothing.
	assign take      = src_valid & run_en & buf_in_ready & ~clear;
	assign vin_ready_o = run_en & buf_in_ready & ~clear & ~ctrl_r[`CFE_CTRL_SRC_BIT];

	assign window = {src_bit, shreg_r};

	always_comb begin
		code_bits = '0;
		for (int c = 0; c < DW; c++) begin
			code_bits[c] = ^(window & tap_mask[c]);
		end
	end

	always_comb begin
		shreg_nxt = shreg_r;
		if (clear) begin
			shreg_nxt = '0;
		end else if (take) begin
			shreg_nxt = {src_bit, shreg_r[STAGES-1:1]};
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shreg_r <= '0;
		end else begin
			shreg_r <= shreg_nxt;
		end
	end

	// Code bits and their valid enter the buffer together, one entry per taken bit.
	conv_fec_skid #(
		.WIDTH (DW),
		.DEPTH (2)
	) u_skid (
		.core_clk_i  (core_clk_i),
		.rstn_i      (rstn_i),
		.in_valid_i  (take),
		.in_ready_o  (buf_in_ready),
		.in_data_i   (code_bits),
		.out_valid_o (buf_out_valid),
		.out_ready_i (buf_out_ready),
		.out_data_o  (buf_out_data),
		.full_o      (buf_full)
	);

	assign buf_out_ready = ctrl_r[`CFE_CTRL_SRC_BIT] ? sw_pop : vout_ready_i;
	assign code_out_o    = buf_out_data;
	assign vout_o        = buf_out_valid & ~ctrl_r[`CFE_CTRL_SRC_BIT];

	// AHB-Lite slave: zero wait states, always OKAY.
	logic addr_ok;
	logic [11:0] radr;
	assign addr_ok     = hsel_i & hready_i & htrans_i[1];
	assign radr        = haddr_i[11:0];
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = hrdata_r;

	// In software mode, reads of the data port pop one entry and a write of DIN pushes one bit.
	assign sw_push = (phase_r == AHB_WRITE) && (wadr_r == `CFE_DIN_OFS);
	assign sw_bit  = hwdata_i[0];
	assign sw_pop  = addr_ok && !hwrite_i && (radr == `CFE_DOUT_OFS) && buf_out_valid;

	always_comb begin
		phase_nxt  = AHB_IDLE;
		wadr_nxt   = wadr_r;
		ctrl_nxt   = ctrl_r;
		in_cnt_nxt = in_cnt_r;
		hrdata_nxt = hrdata_r;
		if (take) begin
			in_cnt_nxt = in_cnt_r + 32'h0000_0001;
		end
		if (phase_r == AHB_WRITE) begin
			unique case (wadr_r)
				`CFE_CTRL_OFS: ctrl_nxt = {29'h0, hwdata_i[2:0]};
				`CFE_CNT_OFS:  in_cnt_nxt = 32'h0000_0000;
				default: ;
			endcase
		end
		if (addr_ok && hwrite_i) begin
			phase_nxt = AHB_WRITE;
			wadr_nxt  = radr;
		end else if (addr_ok) begin
			unique case (radr)
				`CFE_CTRL_OFS:  hrdata_nxt = ctrl_r;
				`CFE_STAT_OFS:  hrdata_nxt = {29'h0, buf_full, buf_out_valid, buf_in_ready};
				`CFE_DOUT_OFS:  hrdata_nxt = {buf_out_valid, 31'(buf_out_data)};
				`CFE_CNT_OFS:   hrdata_nxt = in_cnt_r;
				`CFE_CODES_OFS: hrdata_nxt = 32'(NUM_CODES);
				`CFE_ID_OFS:    hrdata_nxt = `CFE_ID_VALUE;
				default:        hrdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			phase_r  <= AHB_IDLE;
			wadr_r   <= 12'h000;
			ctrl_r   <= `CFE_CTRL_RST;
			in_cnt_r <= 32'h0000_0000;
			hrdata_r <= 32'h0000_0000;
		end else begin
			phase_r  <= phase_nxt;
			wadr_r   <= wadr_nxt;
			ctrl_r   <= ctrl_nxt;
			in_cnt_r <= in_cnt_nxt;
			hrdata_r <= hrdata_nxt;
		end
	end
endmodule : conv_fec_encoder
`default_nettype wire

// ==== conv_fec_regs.svh ====
// Purpose: Offsets, field positions, reset values and fixed figures of the convolutional encoder.
// Assumes: Included by its bare name; definitions only.
// Notes:   Register words are 32-bit aligned on the AHB-Lite slave.
`ifndef CONV_FEC_REGS_SVH
`define CONV_FEC_REGS_SVH

`define CFE_CTRL_OFS      12'h000
`define CFE_STAT_OFS      12'h004
`define CFE_DIN_OFS       12'h008
`define CFE_DOUT_OFS      12'h00c
`define CFE_CNT_OFS       12'h010
`define CFE_CODES_OFS     12'h014
`define CFE_ID_OFS        12'h018

`define CFE_CTRL_EN_BIT   0
`define CFE_CTRL_CLR_BIT  1
`define CFE_CTRL_SRC_BIT  2
`define CFE_CTRL_RST      32'h0000_0001

`define CFE_STAT_INRDY    0
`define CFE_STAT_OUTVAL   1
`define CFE_STAT_FULL     2

`define CFE_DOUT_VAL_BIT  31
`define CFE_CODES_MIN     2
`define CFE_CODES_MAX     7
`define CFE_ID_VALUE      32'h0c0d_e001

`endif

// ==== conv_fec_pkg.sv ====
// Purpose: Types shared by the convolutional encoder files.
// Assumes: Nothing beyond the register header.
// Notes:   Holds types only; numbers live in the header.
`default_nettype none
package conv_fec_pkg;
	typedef enum logic [1:0] {
		AHB_IDLE  = 2'b01,
		AHB_WRITE = 2'b10
	} ahb_phase_t;
endpackage : conv_fec_pkg
`default_nettype wire

// ==== conv_fec_skid.sv ====
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Ready upstream is registered-state based, so a stall costs no word.
`timescale 1ns/1ps
`default_nettype none
module conv_fec_skid #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             core_clk_i,
	input  wire logic             rstn_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  full_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wptr_r;
	logic [AW-1:0]    wptr_nxt;
	logic [AW-1:0]    rptr_r;
	logic [AW-1:0]    rptr_nxt;
	logic [AW:0]      cnt_r;
	logic [AW:0]      cnt_nxt;
	logic             push;
	logic             pop;

	assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem_r[rptr_r];
	assign full_o      = ~in_ready_o;
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_comb begin
		wptr_nxt = wptr_r;
		rptr_nxt = rptr_r;
		cnt_nxt  = cnt_r;
		if (push) begin
			wptr_nxt = (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
		end
		if (pop) begin
			rptr_nxt = (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r  <= '0;
		end else begin
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
			cnt_r  <= cnt_nxt;
		end
	end

	// Storage carries no reset; only written entries are ever presented.
	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_r[wptr_r] <= in_data_i;
		end
	end
endmodule : conv_fec_skid
`default_nettype wire

// ==== conv_fec_stream_partner.sv ====
// Purpose: Bit source and word sink that face the encoder stream pins.
// Assumes: The source sends only while the encoder shows ready.
// Notes:   The gap covers the two-stage pin synchroniser, so no bit is sent into a stale ready.
`timescale 1ns/1ps
`default_nettype none
module conv_fec_stream_partner (
	input  wire logic core_clk_i,
	input  wire logic rstn_i,
	input  wire logic go_i,
	input  wire logic stall_i,
	input  wire logic vin_ready_i,
	output logic      din_o,
	output logic      vin_o,
	output logic      rdy_o
);
	integer     seed = 75;
	logic [2:0] gap_r;
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{din_o, vin_o, rdy_o, gap_r} <= '0;
		end else begin
			rdy_o <= !stall_i && ($random(seed) & 3) != 0;
			if (vin_o) begin
				// A released data line is inverted so that a stale bit never looks valid.
				vin_o <= 1'b0;
				din_o <= ~din_o;
				gap_r <= 3'h5;
			end else if (gap_r != 3'h0) begin
				gap_r <= gap_r - 3'h1;
			end else if (go_i && vin_ready_i) begin
				vin_o <= 1'b1;
				din_o <= 1'($random(seed));
			end
		end
	end
endmodule : conv_fec_stream_partner
`default_nettype wire

// ==== conv_fec_encoder_sva.sv ====
// Purpose: Concurrent checks on the encoder top ports.
// Assumes: Bound from the bench; one clock domain.
// Notes:   Pins pass a two-stage synchroniser, hence the two-cycle lookback on vin.
`timescale 1ns/1ps
`default_nettype none
`include "conv_fec_regs.svh"
module conv_fec_encoder_sva #(
	parameter int NUM_CODES = 2
) (
	input wire logic                 core_clk_i,
	input wire logic                 rstn_i,
	input wire logic                 enc_rst_i,
	input wire logic                 enable_i,
	input wire logic                 vin_i,
	input wire logic                 vin_ready_o,
	input wire logic [NUM_CODES-1:0] code_out_o,
	input wire logic                 vout_o,
	input wire logic                 vout_ready_i,
	input wire logic                 hsel_i,
	input wire logic [31:0]          haddr_i,
	input wire logic [1:0]           htrans_i,
	input wire logic                 hwrite_i,
	input wire logic [31:0]          hrdata_o,
	input wire logic                 hresp_o
);
	logic [1:0] vin_d_r;
	logic [1:0] occ_r;
	logic       took;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	assign took = vin_d_r[1] && vin_ready_o;
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			vin_d_r <= 2'b00;
			occ_r   <= 2'b00;
		end else begin
			vin_d_r <= {vin_d_r[0], vin_i};
			occ_r   <= occ_r + 2'(took) - 2'(vout_o && vout_ready_i);
		end
	end
	AST_TAKE_VOUT: assert property (took |=> vout_o) else $error("no word after a taken bit");
	AST_OCC: assert property (vout_o == (occ_r != 2'd0)) else $error("valid differs from held words");
	AST_ROOM: assert property (occ_r == 2'd2 |-> !vin_ready_o) else $error("ready with a full buffer");
	AST_HOLD: assert property (vout_o && !vout_ready_i |=> vout_o && $stable(code_out_o)) else $error("word lost");
	AST_EN_OFF: assert property (!enable_i [*3] |-> !vin_ready_o) else $error("ready while disabled");
	AST_CLR: assert property (enc_rst_i [*3] |-> !vin_ready_o) else $error("ready while clearing");
	AST_ID: assert property (hsel_i && htrans_i[1] && !hwrite_i && haddr_i[11:0] == `CFE_ID_OFS
		|=> hrdata_o == `CFE_ID_VALUE) else $error("identity read wrong");
	AST_OKAY: assert property (hresp_o == 1'b0) else $error("bus response not okay");
	cover property (vout_o && !vout_ready_i);
	cover property (occ_r == 2'd2);
	cover property (took ##6 took);
endmodule : conv_fec_encoder_sva
`default_nettype wire

// ==== conv_fec_encoder_tb_top.sv ====
// Purpose: Self-checking bench for the encoder over its pins and registers.
// Assumes: Three codes, so one word carries three code bits.
// Notes:   Expected words come from an own shift-register model, queued as bits are sent.
`timescale 1ns/1ps
`default_nettype none
`include "conv_fec_regs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module conv_fec_encoder_tb_top;
	localparam int              K     = 7;
	localparam logic [7*32-1:0] CODES = {128'h0, 32'o165, 32'o171, 32'o133};
	logic core_clk = 1'b0;
	logic rstn, enc_rst, enable, go, stall, din, vin, vin_ready, vout, vout_ready, hsel, hwrite, hreadyout, hresp;
	logic rph = 1'b0;
	logic [2:0] code_out;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [K-2:0] sr = '0;
	logic [2:0] exp_q[$];
	logic [31:0] rq[$];
	int checks = 0, n_fail = 0, nsent = 0;
	always #5 core_clk = ~core_clk;
	conv_fec_encoder #(.CONSTRAINT_LEN(K), .NUM_CODES(3), .CODES(CODES), .USE_ENABLE(1'b1)) u_conv_fec_encoder (
		.core_clk_i(core_clk), .rstn_i(rstn), .enc_rst_i(enc_rst), .enable_i(enable), .din_i(din), .vin_i(vin),
		.vin_ready_o(vin_ready), .code_out_o(code_out), .vout_o(vout), .vout_ready_i(vout_ready), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp));
	conv_fec_stream_partner u_conv_fec_stream_partner (.core_clk_i(core_clk), .rstn_i(rstn), .go_i(go),
		.stall_i(stall), .vin_ready_i(vin_ready), .din_o(din), .vin_o(vin), .rdy_o(vout_ready));
	// One model of the shift register serves both the pin stream and the software feed.
	function automatic logic [2:0] enc_model(input logic b);
		logic [K-1:0] w;
		logic [2:0]   e;
		w = {b, sr};
		for (int i = 0; i < 3; i++) e[i] = ^(w & CODES[i*32 +: K]);
		sr = w[K-1:1];
		return e;
	endfunction : enc_model
	always @(posedge core_clk) begin : note
		if (vin === 1'b1) begin
			exp_q.push_back(enc_model(din));
			nsent++;
		end
	end
	always @(posedge core_clk) begin : watch
		logic [2:0]  e;
		logic [31:0] r;
		if (vout === 1'b1 && vout_ready === 1'b1) begin
			e = exp_q.size() ? exp_q.pop_front() : 3'bxxx;
			`CHK(code_out, e)
		end
		if (rph && hreadyout === 1'b1) begin
			r = rq.pop_front();
			`CHK(hrdata, r)
		end
		rph <= hsel && htrans[1] && !hwrite && hreadyout;
	end
	task automatic print_verdict;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict
	task automatic hwait;
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (n >= 100) begin
			n_fail++;
			print_verdict();
		end
	endtask : hwait
	task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
		if (!w) rq.push_back(e);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0, a};
		hwrite <= w;
		hwait();
		htrans <= 2'b00;
		hwdata <= d;
		hwait();
	endtask : ahb
	task automatic swbit(input logic b);
		logic [2:0] e;
		e = enc_model(b);
		ahb(1, `CFE_DIN_OFS, {31'h0, b}, 0);
		ahb(0, `CFE_STAT_OFS, 0, 32'h3);
		ahb(0, `CFE_DOUT_OFS, 0, {1'b1, 28'h0, e});
	endtask : swbit
	task automatic waitq(input int k);
		int n;
		n = 0;
		while ((k > 0 ? nsent < k : exp_q.size() != 0) && n < 9000) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 9000) begin
			n_fail++;
			print_verdict();
		end
	endtask : waitq
	initial begin
		{rstn, enc_rst, go, stall, hsel, hwrite, haddr, htrans, hwdata} = '0;
		enable = 1'b1;
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		ahb(0, `CFE_CTRL_OFS, 0, `CFE_CTRL_RST);
		ahb(0, `CFE_CODES_OFS, 0, 32'h3);
		ahb(0, `CFE_ID_OFS, 0, `CFE_ID_VALUE);
		ahb(1, 12'h020, 32'hffff_ffff, 0);
		ahb(0, 12'h020, 0, 0);
		ahb(0, `CFE_CTRL_OFS, 0, `CFE_CTRL_RST);
		$display("test registers done");
		go <= 1'b1;
		waitq(24);
		stall <= 1'b1;
		repeat (60) @(posedge core_clk);
		`CHK(vin_ready, 1'b0)
		stall <= 1'b0;
		waitq(32);
		go <= 1'b0;
		repeat (2) @(posedge core_clk);
		waitq(0);
		$display("test stream and stall done");
		// Enable falls as the clear ends, so ready stays low between them and no bit is in flight.
		enc_rst <= 1'b1;
		repeat (4) @(posedge core_clk);
		`CHK(vin_ready, 1'b0)
		enc_rst <= 1'b0;
		enable <= 1'b0;
		sr = '0;
		go <= 1'b1;
		repeat (20) @(posedge core_clk);
		`CHK(vin_ready, 1'b0)
		enable <= 1'b1;
		waitq(nsent + 10);
		go <= 1'b0;
		repeat (2) @(posedge core_clk);
		waitq(0);
		ahb(0, `CFE_CNT_OFS, 0, 32'(nsent));
		ahb(1, `CFE_CNT_OFS, 0, 0);
		ahb(0, `CFE_CNT_OFS, 0, 0);
		$display("test clear, enable and count done");
		ahb(1, `CFE_CTRL_OFS, 32'h5, 0);
		swbit(1'b1);
		swbit(1'b0);
		ahb(1, `CFE_CTRL_OFS, 32'h7, 0);
		sr = '0;
		ahb(1, `CFE_CTRL_OFS, 32'h5, 0);
		swbit(1'b1);
		ahb(0, `CFE_CNT_OFS, 0, 32'h3);
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		ahb(0, `CFE_CTRL_OFS, 0, `CFE_CTRL_RST);
		ahb(0, `CFE_CNT_OFS, 0, 0);
		$display("test software feed and reset done");
		print_verdict();
	end
endmodule : conv_fec_encoder_tb_top
bind conv_fec_encoder conv_fec_encoder_sva #(.NUM_CODES(NUM_CODES)) u_conv_fec_encoder_sva (
	.core_clk_i(core_clk_i), .rstn_i(rstn_i), .enc_rst_i(enc_rst_i), .enable_i(enable_i), .vin_i(vin_i),
	.vin_ready_o(vin_ready_o), .code_out_o(code_out_o), .vout_o(vout_o), .vout_ready_i(vout_ready_i),
	.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hrdata_o(hrdata_o),
	.hresp_o(hresp_o));
`default_nettype wire
